// file: shared/eewr_cfg.svh
// constants of the serial eeprom write path, shared by both ends
// Functional notes
// - master opens write with START, direction zero
// - device expects two eight-bit address bytes
// - inhibit high before data keeps memory unchanged
// - byte write: one data byte, ack, STOP
// - page write up to 64 bytes, one row
// - each data byte acked, low six bits increment
// - master should not overrun the row; this master sends every byte the user queues and leaves row fit to the user
// - program only on STOP in tenth-bit slot
// - device ignores bus while programming
// - program cycle ends within 10 ms
// - master may poll instead of waiting
// - no ack while busy; master retries selection
// - select byte: type, three zeros, direction
// - high address byte first; bit 15 ignored
// - receiver pulls data low on ninth clock
`ifndef EEWR_CFG_SVH
`define EEWR_CFG_SVH
`define EEWR_CLK_HZ 25000000
`define EEWR_PROG_TIME_MS 10
// longest time, so the division rounds down
`define EEWR_PROG_CYCLES (`EEWR_PROG_TIME_MS * (`EEWR_CLK_HZ / 1000))
`define EEWR_PROG_CNT_W 18
`define EEWR_QTR_CYCLES 2'h3
`define EEWR_DEV_TYPE 4'h5
`define EEWR_SEL_FIXED 3'h0
`define EEWR_DIR_WRITE 1'b0
`define EEWR_ADDR_W 15
`define EEWR_ROW_LSB 6
`define EEWR_MEM_BYTES 32768
`define EEWR_ROW_BYTES 64
`define EEWR_BIT_ACK 4'h8
`define EEWR_BIT_GAP 4'h9
`define EEWR_FIFO_W 9
`define EEWR_FIFO_D 32
`endif

// file: shared/eewr_pkg.sv
// state and step types of the serial eeprom write path
package eewr_pkg;
    typedef enum logic [4:0] {
        DEV_IDLE = 5'h01,
        DEV_RECV = 5'h02,
        DEV_ACK = 5'h04,
        DEV_IGNORE = 5'h08,
        DEV_PROG = 5'h10
    } eewr_dev_state_type;
    typedef enum logic [3:0] {
        MST_IDLE = 4'h1,
        MST_START = 4'h2,
        MST_XFER = 4'h4,
        MST_STOP = 4'h8
    } eewr_mst_state_type;
    typedef enum logic [1:0] {
        STEP_DEVSEL = 2'h0,
        STEP_ADDR_HI = 2'h1,
        STEP_ADDR_LO = 2'h2,
        STEP_DATA = 2'h3
    } eewr_step_type;
endpackage

// file: shared/eewr_if.sv
// two-wire link between bus master and eeprom device, wired-and with pull-ups
`timescale 1ns/1ps
interface eewr_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic scl;
    logic sda;
    assign scl = m_scl_oe ? m_scl_o : 1'b1;
    assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (d_sda_oe ? d_sda_o : 1'b1);
    modport master (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe,
                    input scl, input sda);
    modport device (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface

// file: design/eewr_fifo.sv
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
`include "eewr_cfg.svh"
module eewr_fifo #(
    parameter int WIDTH = `EEWR_FIFO_W,
    parameter int DEPTH = `EEWR_FIFO_D
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [AW-1:0] next_wp;
    logic [AW-1:0] next_rp;
    logic [AW:0] next_cnt;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = (cnt != '0);
    assign out_data = store[rp];

    always_comb begin
        next_wp = push ? AW'(wp + 1'b1) : wp;
        next_rp = pop ? AW'(rp + 1'b1) : rp;
        next_cnt = cnt;
        if (push && !pop) begin
            next_cnt = (AW+1)'(cnt + 1'b1);
        end else if (pop && !push) begin
            next_cnt = (AW+1)'(cnt - 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
            in_ready <= 1'b1;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
            // registered so the source sees a clean stall when full
            in_ready <= (next_cnt != (AW+1)'(DEPTH));
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            store[wp] <= in_data;
        end
    end
endmodule

// file: design/eewr_device.sv
// eeprom device end: write decode, row buffer and self-timed program cycle
`timescale 1ns/1ps
`include "eewr_cfg.svh"
module eewr_device #(
    parameter int PROG_CYCLES = `EEWR_PROG_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    eewr_if.device bus,
    input wire logic write_inhibit_pin,
    input wire logic [`EEWR_ADDR_W-1:0] rd_addr,
    output logic [7:0] rd_data,
    output logic busy
);
    localparam logic [`EEWR_PROG_CNT_W-1:0] PROG_LAST = `EEWR_PROG_CNT_W'(PROG_CYCLES - 1);
    localparam logic [7:0] SEL_WRITE = {`EEWR_DEV_TYPE, `EEWR_SEL_FIXED, `EEWR_DIR_WRITE};
    localparam int RW = `EEWR_ROW_LSB;

    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] wi_sync;
    logic scl_d;
    logic sda_d;
    logic scl_s;
    logic sda_s;
    logic wi_s;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    eewr_pkg::eewr_dev_state_type state;
    eewr_pkg::eewr_dev_state_type next_state;
    eewr_pkg::eewr_step_type phase;
    eewr_pkg::eewr_step_type next_phase;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [3:0] bitcnt;
    logic [3:0] next_bitcnt;
    logic [`EEWR_ADDR_W-1:0] addr;
    logic [`EEWR_ADDR_W-1:0] next_addr;
    logic inh;
    logic next_inh;
    logic slot10;
    logic next_slot10;
    logic sda_oe;
    logic next_sda_oe;
    logic wrote;
    logic next_wrote;
    logic [`EEWR_ROW_BYTES-1:0] dvalid;
    logic [`EEWR_ROW_BYTES-1:0] next_dvalid;
    logic [`EEWR_PROG_CNT_W-1:0] pcnt;
    logic [`EEWR_PROG_CNT_W-1:0] next_pcnt;
    logic next_busy;
    logic buf_we;

    logic [7:0] dbuf [`EEWR_ROW_BYTES];
    logic [7:0] mem [`EEWR_MEM_BYTES];
    logic [RW-1:0] commit_idx;
    logic mem_we;
    logic [`EEWR_ADDR_W-1:0] mem_wa;

    // only the second stage of each synchroniser is looked at
    assign scl_s = scl_sync[1];
    assign sda_s = sda_sync[1];
    assign wi_s = wi_sync[1];
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_ev = scl_s && scl_d && sda_d && !sda_s;
    assign stop_ev = scl_s && scl_d && !sda_d && sda_s;

    always_ff @(posedge clk) begin
        if (srst) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            wi_sync <= 2'h0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], bus.scl};
            sda_sync <= {sda_sync[0], bus.sda};
            wi_sync <= {wi_sync[0], write_inhibit_pin};
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    always_comb begin
        next_state = state;
        next_phase = phase;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_addr = addr;
        next_inh = inh;
        next_slot10 = slot10;
        next_sda_oe = sda_oe;
        next_wrote = wrote;
        next_dvalid = dvalid;
        next_pcnt = pcnt;
        next_busy = busy;
        buf_we = 1'b0;
        unique case (state)
            eewr_pkg::DEV_RECV: begin
                if (scl_rise) begin
                    next_shreg = {shreg[6:0], sda_s};
                    next_bitcnt = bitcnt + 4'h1;
                end else if (scl_fall) begin
                    next_slot10 = 1'b0;
                    if (bitcnt == `EEWR_BIT_ACK) begin
                        next_state = eewr_pkg::DEV_ACK;
                        unique case (phase)
                            eewr_pkg::STEP_DEVSEL: begin
                                if (shreg == SEL_WRITE) begin
                                    next_sda_oe = 1'b1;
                                    next_phase = eewr_pkg::STEP_ADDR_HI;
                                end else begin
                                    // read selections belong to the read path
                                    next_state = eewr_pkg::DEV_IGNORE;
                                end
                            end
                            eewr_pkg::STEP_ADDR_HI: begin
                                // top bit of the high byte is dropped
                                next_addr[`EEWR_ADDR_W-1:8] = shreg[6:0];
                                next_sda_oe = 1'b1;
                                next_phase = eewr_pkg::STEP_ADDR_LO;
                            end
                            eewr_pkg::STEP_ADDR_LO: begin
                                next_addr[7:0] = shreg;
                                next_sda_oe = 1'b1;
                                next_phase = eewr_pkg::STEP_DATA;
                            end
                            eewr_pkg::STEP_DATA: begin
                                if (!inh) begin
                                    buf_we = 1'b1;
                                    next_dvalid[addr[RW-1:0]] = 1'b1;
                                    // row wraps, previous bytes may be overwritten
                                    next_addr[RW-1:0] = addr[RW-1:0] + 6'h1;
                                    next_wrote = 1'b1;
                                    next_sda_oe = 1'b1;
                                end
                            end
                        endcase
                    end
                end
            end
            eewr_pkg::DEV_ACK: begin
                if (scl_fall) begin
                    next_sda_oe = 1'b0;
                    next_state = eewr_pkg::DEV_RECV;
                    next_bitcnt = 4'h0;
                    next_slot10 = sda_oe;
                end
            end
            eewr_pkg::DEV_PROG: begin
                next_pcnt = pcnt + `EEWR_PROG_CNT_W'(1);
                if (pcnt == PROG_LAST) begin
                    next_state = eewr_pkg::DEV_IDLE;
                    next_busy = 1'b0;
                    next_dvalid = '0;
                    next_wrote = 1'b0;
                end
            end
            eewr_pkg::DEV_IDLE, eewr_pkg::DEV_IGNORE: begin
                next_state = state;
            end
        endcase
        // while programming the bus is not even watched
        if (state != eewr_pkg::DEV_PROG) begin
            if (state != eewr_pkg::DEV_IDLE && phase != eewr_pkg::STEP_DATA) begin
                next_inh = inh | wi_s;
            end
            if (start_ev) begin
                next_state = eewr_pkg::DEV_RECV;
                next_phase = eewr_pkg::STEP_DEVSEL;
                next_bitcnt = 4'h0;
                next_inh = wi_s;
                next_slot10 = 1'b0;
                next_sda_oe = 1'b0;
                next_wrote = 1'b0;
                next_dvalid = '0;
            end else if (stop_ev) begin
                next_state = eewr_pkg::DEV_IDLE;
                next_sda_oe = 1'b0;
                // a stop one bit after an ack, with data taken, starts the cycle
                if (state == eewr_pkg::DEV_RECV && slot10 && bitcnt == 4'h1 &&
                    wrote && !inh) begin
                    next_state = eewr_pkg::DEV_PROG;
                    next_busy = 1'b1;
                    next_pcnt = '0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= eewr_pkg::DEV_IDLE;
            phase <= eewr_pkg::STEP_DEVSEL;
            shreg <= 8'h00;
            bitcnt <= 4'h0;
            addr <= '0;
            inh <= 1'b0;
            slot10 <= 1'b0;
            sda_oe <= 1'b0;
            wrote <= 1'b0;
            dvalid <= '0;
            pcnt <= '0;
            busy <= 1'b0;
            bus.d_sda_oe <= 1'b0;
            bus.d_sda_o <= 1'b0;
        end else begin
            state <= next_state;
            phase <= next_phase;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            addr <= next_addr;
            inh <= next_inh;
            slot10 <= next_slot10;
            sda_oe <= next_sda_oe;
            wrote <= next_wrote;
            dvalid <= next_dvalid;
            pcnt <= next_pcnt;
            busy <= next_busy;
            bus.d_sda_oe <= next_sda_oe;
            bus.d_sda_o <= 1'b0;
        end
    end

    // commit walks the row one byte per cycle at the start of the cycle;
    // untouched bytes keep their old contents
    assign commit_idx = pcnt[RW-1:0];
    assign mem_we = busy && (pcnt[`EEWR_PROG_CNT_W-1:RW] == '0) && dvalid[commit_idx];
    assign mem_wa = {addr[`EEWR_ADDR_W-1:RW], commit_idx};

    always_ff @(posedge clk) begin
        if (buf_we) begin
            dbuf[addr[RW-1:0]] <= shreg;
        end
        if (mem_we) begin
            mem[mem_wa] <= dbuf[commit_idx];
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// file: design/eewr_master.sv
// bus master end: fifo-fed page writer with acknowledge polling
`timescale 1ns/1ps
`include "eewr_cfg.svh"
module eewr_master (
    input wire logic clk,
    input wire logic srst,
    eewr_if.master bus,
    input wire logic [15:0] wr_addr,
    input wire logic [`EEWR_FIFO_W-1:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    output logic done,
    output logic data_nack
);
    localparam logic [7:0] SEL_WRITE = {`EEWR_DEV_TYPE, `EEWR_SEL_FIXED, `EEWR_DIR_WRITE};

    logic [`EEWR_FIFO_W-1:0] f_data;
    logic f_valid;
    logic pop;
    logic [1:0] sda_sync;
    logic sda_s;
    eewr_pkg::eewr_mst_state_type st;
    eewr_pkg::eewr_mst_state_type next_st;
    eewr_pkg::eewr_step_type step;
    eewr_pkg::eewr_step_type next_step;
    logic [1:0] q;
    logic [1:0] next_q;
    logic [1:0] qcnt;
    logic [1:0] next_qcnt;
    logic [3:0] bitn;
    logic [3:0] next_bitn;
    logic [15:0] addr_q;
    logic [15:0] next_addr_q;
    logic retry;
    logic next_retry;
    logic scl_oe;
    logic next_scl_oe;
    logic sda_oe;
    logic next_sda_oe;
    logic next_done;
    logic next_nack;
    logic [7:0] cur_byte;
    logic stall;
    logic tick;

    // the fifo decouples the user from the slow bus; its ready is wr_ready
    eewr_fifo #(.WIDTH(`EEWR_FIFO_W), .DEPTH(`EEWR_FIFO_D)) u_fifo (
        .clk(clk),
        .srst(srst),
        .in_data(wr_data),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(pop)
    );

    assign sda_s = sda_sync[1];

    always_comb begin
        unique case (step)
            eewr_pkg::STEP_DEVSEL: cur_byte = SEL_WRITE;
            eewr_pkg::STEP_ADDR_HI: cur_byte = addr_q[15:8];
            eewr_pkg::STEP_ADDR_LO: cur_byte = addr_q[7:0];
            eewr_pkg::STEP_DATA: cur_byte = f_data[7:0];
        endcase
    end

    // scl stretches low between data bytes while the fifo is empty
    assign stall = (st == eewr_pkg::MST_XFER) && (q == 2'h3) && (bitn == `EEWR_BIT_GAP) &&
                   (step == eewr_pkg::STEP_DATA) && !f_valid;
    assign tick = (qcnt == `EEWR_QTR_CYCLES) && !stall;

    always_comb begin
        next_st = st;
        next_step = step;
        next_q = tick ? q + 2'h1 : q;
        next_qcnt = tick ? 2'h0 : (stall ? qcnt : qcnt + 2'h1);
        next_bitn = bitn;
        next_addr_q = addr_q;
        next_retry = retry;
        next_scl_oe = scl_oe;
        next_sda_oe = sda_oe;
        next_done = 1'b0;
        next_nack = data_nack;
        pop = 1'b0;
        unique case (st)
            eewr_pkg::MST_IDLE: begin
                next_q = 2'h0;
                next_qcnt = 2'h0;
                if (f_valid) begin
                    next_st = eewr_pkg::MST_START;
                    next_addr_q = wr_addr;
                    next_step = eewr_pkg::STEP_DEVSEL;
                    next_retry = 1'b0;
                    next_nack = 1'b0;
                end
            end
            eewr_pkg::MST_START: begin
                if (tick) begin
                    unique case (q)
                        2'h1: next_sda_oe = 1'b1;
                        2'h2: next_scl_oe = 1'b1;
                        2'h3: begin
                            next_st = eewr_pkg::MST_XFER;
                            next_bitn = 4'h0;
                            next_sda_oe = !cur_byte[7];
                        end
                        default: next_sda_oe = 1'b0;
                    endcase
                end
            end
            eewr_pkg::MST_XFER: begin
                if (tick) begin
                    unique case (q)
                        2'h0: next_scl_oe = 1'b0;
                        2'h1: next_scl_oe = 1'b0;
                        2'h2: begin
                            next_scl_oe = 1'b1;
                            if (bitn == `EEWR_BIT_ACK) begin
                                next_bitn = `EEWR_BIT_GAP;
                                unique case (step)
                                    eewr_pkg::STEP_DEVSEL: begin
                                        if (sda_s) begin
                                            next_retry = 1'b1;
                                            next_st = eewr_pkg::MST_STOP;
                                            next_bitn = `EEWR_BIT_ACK;
                                        end else begin
                                            next_step = eewr_pkg::STEP_ADDR_HI;
                                        end
                                    end
                                    eewr_pkg::STEP_ADDR_HI: next_step = eewr_pkg::STEP_ADDR_LO;
                                    eewr_pkg::STEP_ADDR_LO: next_step = eewr_pkg::STEP_DATA;
                                    eewr_pkg::STEP_DATA: begin
                                        pop = 1'b1;
                                        next_nack = data_nack | sda_s;
                                        // the user marks the last byte; row fit is the user's
                                        if (f_data[8]) begin
                                            next_st = eewr_pkg::MST_STOP;
                                            next_bitn = `EEWR_BIT_ACK;
                                        end
                                    end
                                endcase
                            end
                        end
                        2'h3: begin
                            if (bitn == `EEWR_BIT_GAP) begin
                                next_bitn = 4'h0;
                                next_sda_oe = !cur_byte[7];
                            end else begin
                                next_bitn = bitn + 4'h1;
                                next_sda_oe = (bitn < 4'h7) ? !cur_byte[3'(4'h6 - bitn)] : 1'b0;
                            end
                        end
                    endcase
                end
            end
            eewr_pkg::MST_STOP: begin
                if (tick) begin
                    unique case (q)
                        2'h0: next_scl_oe = 1'b0;
                        2'h1: next_sda_oe = 1'b0;
                        2'h2: next_sda_oe = 1'b0;
                        2'h3: begin
                            if (bitn == `EEWR_BIT_ACK) begin
                                next_sda_oe = 1'b1;
                                next_bitn = 4'h0;
                            end else if (retry) begin
                                next_st = eewr_pkg::MST_START;
                                next_step = eewr_pkg::STEP_DEVSEL;
                                next_retry = 1'b0;
                            end else begin
                                next_st = eewr_pkg::MST_IDLE;
                                next_done = 1'b1;
                            end
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sda_sync <= 2'h3;
            st <= eewr_pkg::MST_IDLE;
            step <= eewr_pkg::STEP_DEVSEL;
            q <= 2'h0;
            qcnt <= 2'h0;
            bitn <= 4'h0;
            addr_q <= 16'h0000;
            retry <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            done <= 1'b0;
            data_nack <= 1'b0;
            bus.m_scl_oe <= 1'b0;
            bus.m_sda_oe <= 1'b0;
            bus.m_scl_o <= 1'b0;
            bus.m_sda_o <= 1'b0;
        end else begin
            sda_sync <= {sda_sync[0], bus.sda};
            st <= next_st;
            step <= next_step;
            q <= next_q;
            qcnt <= next_qcnt;
            bitn <= next_bitn;
            addr_q <= next_addr_q;
            retry <= next_retry;
            scl_oe <= next_scl_oe;
            sda_oe <= next_sda_oe;
            done <= next_done;
            data_nack <= next_nack;
            bus.m_scl_oe <= next_scl_oe;
            bus.m_sda_oe <= next_sda_oe;
            bus.m_scl_o <= 1'b0;
            bus.m_sda_o <= 1'b0;
        end
    end
endmodule

// file: sim/eewr_checker.sv
// wire-level checks of the two-wire eeprom link
`timescale 1ns/1ps
module eewr_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic m_sda_oe,
    input wire logic d_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic pscl, psda;
    logic [3:0] cnt;
    wire start = scl && pscl && psda && !sda;
    wire stop = scl && pscl && !psda && sda;
    wire rise = scl && !pscl;
    // bit index since start; the ninth clock of a byte is index 8
    always_ff @(posedge clk) begin
        pscl <= scl;
        psda <= sda;
        if (srst || start) cnt <= 4'h0;
        else if (rise) cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    ack_slot_a: assert property (rise && d_sda_oe |-> cnt == 4'h8)
        else $error("ack off ninth clock");
    ack_setup_a: assert property ($rose(d_sda_oe) |-> !scl)
        else $error("ack set with clock high");
    ack_hold_a: assert property (scl && pscl |-> $stable(d_sda_oe))
        else $error("ack moved with clock high");
    ack_len_a: assert property ($rose(d_sda_oe) |-> d_sda_oe[*8] ##[1:32] !d_sda_oe)
        else $error("ack length off");
    line_free_a: assert property (rise && cnt == 4'h8 |-> !m_sda_oe)
        else $error("master held data on ninth clock");
    data_hold_a: assert property (scl && pscl && !start && !stop |-> sda == psda)
        else $error("data moved with clock high");
    stop_slot_a: assert property (stop |-> cnt == 4'h1)
        else $error("stop outside tenth slot");
    start_frame_a: assert property (start |-> ##[1:8] !scl)
        else $error("clock not low after start");
    cover property (stop);
    cover property (rise && cnt == 4'h8 && sda);
    cover property ($rose(d_sda_oe));
endmodule

// file: sim/serial_eeprom_write_control_tb.sv
// bench: master and device joined over the link, checked against a byte model
`timescale 1ns/1ps
module serial_eeprom_write_control_tb;
    localparam int PC = 100;
    localparam logic [15:0] RA [5] = '{16'h0123, 16'h80BC, 16'h1240, 16'h1250, 16'h0123};
    localparam int RN [5] = '{1, 8, 64, 4, 1};
    localparam logic [7:0] RS [5] = '{8'h5A, 8'h10, 8'h80, 8'hE0, 8'hC3};
    localparam logic RI [5] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
    logic clk = 1'h0, srst = 1'h1, inh = 1'h0, wr_valid = 1'h0, full = 1'h0;
    logic [14:0] rd_addr = 15'h0000;
    logic [15:0] wr_addr = 16'h0000;
    logic [8:0] wr_data = 9'h000;
    logic [7:0] rd_data;
    logic busy, wr_ready, done, data_nack;
    int mismatches = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [7:0] mem [int];
    eewr_if bus ();
    eewr_master eewr_master_inst (.clk, .srst, .bus(bus.master), .wr_addr, .wr_data,
        .wr_valid, .wr_ready, .done, .data_nack);
    eewr_device #(.PROG_CYCLES(PC)) eewr_device_inst (.clk, .srst, .bus(bus.device),
        .write_inhibit_pin(inh), .rd_addr, .rd_data, .busy);
    eewr_checker eewr_checker_inst (.clk, .srst, .m_sda_oe(bus.m_sda_oe),
        .d_sda_oe(bus.d_sda_oe), .scl(bus.scl), .sda(bus.sda));
    initial forever #20 clk = ~clk;
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (e !== g) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask
    // the whole run needs about half of this; a stuck link ends here
    always @(posedge clk) begin
        cyc <= cyc + 1;
        full <= full | (wr_ready === 1'h0);
        if (cyc == 40000) begin
            mismatches++;
            results();
        end
    end
    task automatic cmp(input logic [15:0] a);
        for (int j = 0; j < 64; j++) begin
            if (mem.exists({a[14:6], 6'(j)})) begin
                @(posedge clk);
                rd_addr <= {a[14:6], 6'(j)};
                @(posedge clk);
                @(negedge clk);
                chk("mem", 16'(mem[{a[14:6], 6'(j)}]), 16'(rd_data));
            end
        end
    endtask
    task automatic go(input logic [15:0] a, input int n, input logic [7:0] s, input logic i);
        @(posedge clk);
        inh <= i;
        wr_addr <= a;
        for (int k = 0; k < n; k++) begin
            wr_data <= {k == n - 1, s + 8'(k)};
            wr_valid <= 1'h1;
            do @(negedge clk); while (wr_ready !== 1'h1);
            @(posedge clk);
            if (!i) mem[{a[14:6], a[5:0] + 6'(k)}] = s + 8'(k);
        end
        wr_valid <= 1'h0;
        do @(negedge clk); while (done !== 1'h1);
        chk("data_nack", 16'(i), 16'(data_nack));
    endtask
    task automatic settle(input logic [15:0] a, input logic i);
        int t;
        for (t = 0; t < 8 && busy !== 1'h1; t++) @(negedge clk);
        chk("program start", 16'(!i), 16'(busy));
        for (t = 0; busy === 1'h1; t++) @(negedge clk);
        chk("program time", 16'h0001, 16'(t <= PC));
        cmp(a);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        @(negedge clk);
        chk("reset", 16'h0001, {12'h000, busy, done, data_nack, wr_ready});
        $display("reset check done");
        repeat (3) @(posedge clk);
        for (int r = 0; r < 5; r++) begin
            go(RA[r], RN[r], RS[r], RI[r]);
            settle(RA[r], RI[r]);
            $display("row %0d done", r);
        end
        chk("fifo refused", 16'h0001, 16'(full));
        // second write lands while the first programs, so the master must poll
        go(16'h2000, 2, 8'h33, 1'h0);
        go(16'h2040, 2, 8'h44, 1'h0);
        settle(16'h2040, 1'h0);
        cmp(16'h2000);
        $display("polling test done");
        // reset while a program cycle runs must drop busy and leave the link idle
        go(16'h2080, 1, 8'h55, 1'h0);
        chk("busy before reset", 16'h0001, 16'(busy));
        @(posedge clk);
        srst <= 1'h1;
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        @(negedge clk);
        chk("reset mid-run", 16'h0001, {12'h000, busy, done, data_nack, wr_ready});
        chk("link idle", 16'h0003, {14'h0000, bus.scl, bus.sda});
        $display("reset test done");
        results();
    end
endmodule
